//--- core/irpc_defines.svh
// register map, field positions, reset values and timing constants of the ir port
`ifndef IRPC_DEFINES_SVH
`define IRPC_DEFINES_SVH

`define IRPC_ADDR_W 12
`define IRPC_TX_LOW_IDX 12'h0204
`define IRPC_TX_HIGH_IDX 12'h0205
`define IRPC_RX_LOW_IDX 12'h0208
`define IRPC_RX_HIGH_IDX 12'h0209
`define IRPC_CTRL1_IDX 12'h0200
`define IRPC_CTRL2_IDX 12'h0201
`define IRPC_STAT_IDX 12'h020A

`define IRPC_CTRL1_MOD_BIT 5
`define IRPC_CTRL1_DEMOD_BIT 4
`define IRPC_CTRL2_LOOP_BIT 5
`define IRPC_CTRL2_POL_BIT 4
`define IRPC_CTRL2_TX_POLICY_BIT 3
`define IRPC_CTRL2_RX_POLICY_BIT 2
`define IRPC_CTRL2_TX_ON_BIT 1
`define IRPC_CTRL2_RX_ON_BIT 0

`define IRPC_DIV_BYTE_RESET 8'hff
`define IRPC_DIV_RESET 16'hffff
`define IRPC_FIFO_LVL_W 5
`define IRPC_FIFO_HALF 5'h08
`define IRPC_DEMOD_HOLD 5'h10

`define IRPC_RESP_OKAY 2'h0
`define IRPC_RESP_SLVERR 2'h2

`endif

//--- core/irpc_pkg.sv
// types shared by the ir port control block
package irpc_pkg;

  typedef struct packed {
    logic tx_mod_on;
    logic rx_carrier_detect_on;
  } irpc_ctrl1_t;

  typedef struct packed {
    logic internal_loopback;
    logic carrier_polarity_invert;
    logic tx_request_policy;
    logic rx_request_policy;
    logic transmitter_on;
    logic receiver_on;
  } irpc_ctrl2_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } irpc_modulus_t;

endpackage

//--- core/irpc_divider.sv
// bit clock down counter issuing one-cycle enable pulses
`timescale 1ns/1ps
`include "irpc_defines.svh"

module irpc_divider (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] modulus,
  input wire logic reload,
  input wire logic run,
  output logic tick
);

  logic [15:0] cnt_ff;
  logic tick_ff;

  // period equals modulus cycles; a stopped or reloaded counter restarts full
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= `IRPC_DIV_RESET;
    end else if (reload || !run) begin
      cnt_ff <= modulus;
    end else if (cnt_ff == 16'h0001) begin
      cnt_ff <= modulus;
    end else begin
      cnt_ff <= cnt_ff - 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= run && !reload && (cnt_ff == 16'h0001);
    end
  end

  assign tick = tick_ff;

endmodule

//--- core/irpc_top.sv
// ir port control, bit clock dividers, carrier modulator and receive front end
`timescale 1ns/1ps
`include "irpc_defines.svh"

module irpc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`IRPC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`IRPC_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic tx_symbol,
  input wire logic tx_busy,
  input wire logic [`IRPC_FIFO_LVL_W-1:0] tx_fifo_level,
  input wire logic [`IRPC_FIFO_LVL_W-1:0] rx_fifo_level,
  input wire logic rx_pin,
  output logic infrared_out_pin,
  output logic rx_symbol,
  output logic tx_clk_en,
  output logic rx_clk_en,
  output logic tx_request,
  output logic rx_request,
  output logic tx_enabled,
  output logic rx_enabled
);

  ////////////////////////////////////////////////////////////////////////////
  // register bus slave
  logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff, do_write, wr_hit, rd_hit, lane0;
  logic [`IRPC_ADDR_W-1:0] awaddr_ff, widx, ridx;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [7:0] rd_byte;
  irpc_pkg::irpc_ctrl1_t ctrl1_ff;
  irpc_pkg::irpc_ctrl2_t ctrl2_ff;
  irpc_pkg::irpc_modulus_t tx_mod_ff;
  irpc_pkg::irpc_modulus_t rx_mod_ff;
  logic tx_reload_ff, rx_reload_ff;

  // prot bits carry nothing for this block
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready = !w_hold_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
  // printed offsets are word indices; byte address is four times the index
  assign widx = {2'b00, awaddr_ff[`IRPC_ADDR_W-1:2]};
  assign ridx = {2'b00, s_axi_araddr[`IRPC_ADDR_W-1:2]};
  assign lane0 = wstrb_ff[0];

  always_comb begin
    case (widx)
      `IRPC_CTRL1_IDX, `IRPC_CTRL2_IDX, `IRPC_TX_LOW_IDX,
      `IRPC_TX_HIGH_IDX, `IRPC_RX_LOW_IDX, `IRPC_RX_HIGH_IDX: wr_hit = 1'b1;
      // status is read only; a write to it is refused
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      awaddr_ff <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `IRPC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? `IRPC_RESP_OKAY : `IRPC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // control and modulus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1_ff <= '0;
      ctrl2_ff <= '0;
    end else if (do_write && lane0) begin
      if (widx == `IRPC_CTRL1_IDX) begin
        ctrl1_ff.tx_mod_on <= wdata_ff[`IRPC_CTRL1_MOD_BIT];
        ctrl1_ff.rx_carrier_detect_on <= wdata_ff[`IRPC_CTRL1_DEMOD_BIT];
      end
      if (widx == `IRPC_CTRL2_IDX) begin
        ctrl2_ff.internal_loopback <= wdata_ff[`IRPC_CTRL2_LOOP_BIT];
        ctrl2_ff.carrier_polarity_invert <= wdata_ff[`IRPC_CTRL2_POL_BIT];
        ctrl2_ff.tx_request_policy <= wdata_ff[`IRPC_CTRL2_TX_POLICY_BIT];
        ctrl2_ff.rx_request_policy <= wdata_ff[`IRPC_CTRL2_RX_POLICY_BIT];
        ctrl2_ff.transmitter_on <= wdata_ff[`IRPC_CTRL2_TX_ON_BIT];
        ctrl2_ff.receiver_on <= wdata_ff[`IRPC_CTRL2_RX_ON_BIT];
      end
    end
  end

  // a zero modulus is not guarded; software keeps it nonzero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_mod_ff <= {`IRPC_DIV_BYTE_RESET, `IRPC_DIV_BYTE_RESET};
      rx_mod_ff <= {`IRPC_DIV_BYTE_RESET, `IRPC_DIV_BYTE_RESET};
    end else if (do_write && lane0) begin
      if (widx == `IRPC_TX_LOW_IDX) tx_mod_ff.low <= wdata_ff[7:0];
      if (widx == `IRPC_TX_HIGH_IDX) tx_mod_ff.high <= wdata_ff[7:0];
      if (widx == `IRPC_RX_LOW_IDX) rx_mod_ff.low <= wdata_ff[7:0];
      if (widx == `IRPC_RX_HIGH_IDX) rx_mod_ff.high <= wdata_ff[7:0];
    end
  end

  // reload one cycle after the byte lands, so the counter sees the new value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_reload_ff <= 1'b0;
      rx_reload_ff <= 1'b0;
    end else begin
      tx_reload_ff <= do_write && lane0 &&
        (widx == `IRPC_TX_LOW_IDX || widx == `IRPC_TX_HIGH_IDX);
      rx_reload_ff <= do_write && lane0 &&
        (widx == `IRPC_RX_LOW_IDX || widx == `IRPC_RX_HIGH_IDX);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  always_comb begin
    rd_hit = 1'b1;
    rd_byte = 8'h00;
    case (ridx)
      `IRPC_CTRL1_IDX: begin
        rd_byte[`IRPC_CTRL1_MOD_BIT] = ctrl1_ff.tx_mod_on;
        rd_byte[`IRPC_CTRL1_DEMOD_BIT] = ctrl1_ff.rx_carrier_detect_on;
      end
      `IRPC_CTRL2_IDX: rd_byte = {2'b00, ctrl2_ff};
      `IRPC_TX_LOW_IDX: rd_byte = tx_mod_ff.low;
      `IRPC_TX_HIGH_IDX: rd_byte = tx_mod_ff.high;
      `IRPC_RX_LOW_IDX: rd_byte = rx_mod_ff.low;
      `IRPC_RX_HIGH_IDX: rd_byte = rx_mod_ff.high;
      `IRPC_STAT_IDX: rd_byte = {4'h0, tx_busy, infrared_out_pin, tx_request, rx_request};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `IRPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_byte};
      rresp_ff <= rd_hit ? `IRPC_RESP_OKAY : `IRPC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // bit clock dividers
  logic tx_tick, rx_tick;
  irpc_divider u_tx_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .modulus(tx_mod_ff),
    .reload(tx_reload_ff),
    .run(ctrl2_ff.transmitter_on),
    .tick(tx_tick)
  );

  irpc_divider u_rx_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .modulus(rx_mod_ff),
    .reload(rx_reload_ff),
    .run(ctrl2_ff.receiver_on),
    .tick(rx_tick)
  );

  assign tx_clk_en = tx_tick;
  assign rx_clk_en = rx_tick;
  assign tx_enabled = ctrl2_ff.transmitter_on;
  assign rx_enabled = ctrl2_ff.receiver_on;

  ////////////////////////////////////////////////////////////////////////////
  // transmit modulator
  logic pin_ff, carrier_ff, tx_mark, tx_live;
  // a mark is a one, or a zero when the polarity is inverted
  assign tx_mark = tx_symbol ^ ctrl2_ff.carrier_polarity_invert;
  assign tx_live = ctrl2_ff.transmitter_on && tx_busy;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carrier_ff <= 1'b0;
    end else if (!tx_live || !ctrl1_ff.tx_mod_on || !tx_mark) begin
      carrier_ff <= 1'b0;
    end else if (tx_tick) begin
      carrier_ff <= !carrier_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_ff <= 1'b0;
    end else if (ctrl1_ff.tx_mod_on) begin
      pin_ff <= carrier_ff;
    end else if (!tx_live) begin
      pin_ff <= ctrl2_ff.carrier_polarity_invert;
    end else begin
      pin_ff <= tx_mark;
    end
  end

  // pin keeps showing transmit data in loopback
  assign infrared_out_pin = pin_ff;

  ////////////////////////////////////////////////////////////////////////////
  // receive front end
  logic rx_meta_ff, rx_sync_ff, rx_src, rx_prev_ff, rx_edge, rx_symbol_ff;
  logic [4:0] hold_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_ff <= 1'b0;
      rx_sync_ff <= 1'b0;
    end else begin
      rx_meta_ff <= rx_pin;
      rx_sync_ff <= rx_meta_ff;
    end
  end

  assign rx_src = ctrl2_ff.internal_loopback ? pin_ff : rx_sync_ff;
  assign rx_edge = rx_src ^ rx_prev_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_prev_ff <= 1'b0;
    end else begin
      rx_prev_ff <= rx_src;
    end
  end

  // a mark lasts while edges keep coming within the hold window of rx ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_ff <= 5'h00;
    end else if (!ctrl2_ff.receiver_on) begin
      hold_ff <= 5'h00;
    end else if (rx_edge) begin
      hold_ff <= `IRPC_DEMOD_HOLD;
    end else if (rx_tick && hold_ff != 5'h00) begin
      hold_ff <= hold_ff - 5'h01;
    end
  end

  // no receive inversion in hardware; software owns it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_symbol_ff <= 1'b0;
    end else if (!ctrl2_ff.receiver_on) begin
      rx_symbol_ff <= 1'b0;
    end else if (ctrl1_ff.rx_carrier_detect_on) begin
      rx_symbol_ff <= rx_edge || (hold_ff != 5'h00);
    end else begin
      rx_symbol_ff <= rx_src;
    end
  end

  assign rx_symbol = rx_symbol_ff;

  ////////////////////////////////////////////////////////////////////////////
  // service requests
  logic tx_req_ff, rx_req_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_req_ff <= 1'b0;
    end else if (ctrl2_ff.tx_request_policy) begin
      tx_req_ff <= !tx_busy;
    end else begin
      tx_req_ff <= (tx_fifo_level <= `IRPC_FIFO_HALF);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_req_ff <= 1'b0;
    end else if (ctrl2_ff.rx_request_policy) begin
      rx_req_ff <= (rx_fifo_level != 5'h00);
    end else begin
      rx_req_ff <= (rx_fifo_level >= `IRPC_FIFO_HALF);
    end
  end

  assign tx_request = tx_req_ff;
  assign rx_request = rx_req_ff;

endmodule

//--- verification/irpc_top_props.sv
// port assertions for the ir port control block
`timescale 1ns/1ps
`include "irpc_defines.svh"
module irpc_top_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_busy,
  input wire logic [`IRPC_FIFO_LVL_W-1:0] tx_fifo_level,
  input wire logic [`IRPC_FIFO_LVL_W-1:0] rx_fifo_level,
  input wire logic tx_request,
  input wire logic rx_request,
  input wire logic tx_enabled,
  input wire logic rx_enabled,
  input wire logic tx_clk_en,
  input wire logic rx_clk_en,
  input wire logic rx_symbol
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // both policies agree at these corners, so the policy bit need not be seen
  tx_req_on_a: assert property (!tx_busy && tx_fifo_level <= 5'h08 |=> tx_request)
    else $error("tx request missing");
  tx_req_off_a: assert property (tx_busy && tx_fifo_level > 5'h08 |=> !tx_request)
    else $error("tx request stuck");
  rx_req_on_a: assert property (rx_fifo_level >= 5'h08 |=> rx_request)
    else $error("rx request missing");
  rx_req_off_a: assert property (rx_fifo_level == 5'h00 |=> !rx_request)
    else $error("rx request stuck");
  // one cycle of grace: the tick is registered from the old enable
  tx_tick_off_a: assert property (!tx_enabled && !$past(tx_enabled) |-> !tx_clk_en)
    else $error("tx tick while off");
  rx_tick_off_a: assert property (!rx_enabled && !$past(rx_enabled) |-> !rx_clk_en)
    else $error("rx tick while off");
  rx_sym_off_a: assert property (!rx_enabled && !$past(rx_enabled) |-> !rx_symbol)
    else $error("rx symbol while off");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken early");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response held after handshake");
endmodule

bind irpc_top irpc_top_props u_props (.aclk, .aresetn, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready,
  .tx_busy, .tx_fifo_level, .rx_fifo_level, .tx_request, .rx_request, .tx_enabled,
  .rx_enabled, .tx_clk_en, .rx_clk_en, .rx_symbol);

//--- verification/irpc_ir_link.sv
// emitter and detector model at the ir pins
`timescale 1ns/1ps
module irpc_ir_link (
  input wire logic aclk,
  input wire logic infrared_out_pin,
  input wire logic light,
  output logic rx_pin,
  output logic [7:0] flashes
);
  logic last_ff;
  initial flashes = 8'h00;
  // detector passes light as is; any inversion is up to software
  assign rx_pin = light;
  always @(posedge aclk) begin
    last_ff <= infrared_out_pin;
    if (last_ff !== infrared_out_pin) flashes <= flashes + 8'h01;
  end
endmodule

//--- verification/irpc_top_tb.sv
// self-checking bench for the ir port control block
`timescale 1ns/1ps
module irpc_top_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, tx_symbol, tx_busy, rx_pin, infrared_out_pin, rx_symbol, light;
  logic tx_clk_en, rx_clk_en, tx_request, rx_request, tx_enabled, rx_enabled;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] tx_fifo_level, rx_fifo_level;
  logic [7:0] flashes;
  int n_errors, total_checks;

  irpc_top dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .tx_symbol, .tx_busy, .tx_fifo_level, .rx_fifo_level, .rx_pin,
    .infrared_out_pin, .rx_symbol, .tx_clk_en, .rx_clk_en, .tx_request, .rx_request,
    .tx_enabled, .rx_enabled);
  irpc_ir_link u_link (.aclk, .infrared_out_pin, .light, .rx_pin, .flashes);

  always #50 aclk = ~aclk;

  ////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int i);
    if (i >= 99) begin
      n_errors++;
      $display("[ERR] %0t wait ran out", $time);
      finish_test;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int i;
    logic ta, tw;
    ta = 0;
    tw = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 99; i++) begin
      @(posedge aclk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      s_axi_awvalid <= !ta;
      s_axi_wvalid <= !tw;
      if (s_axi_bvalid) break;
    end
    tmo(i);
    chk(32'(s_axi_bresp), 32'h0000_0000);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    logic ta;
    ta = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 99; i++) begin
      @(posedge aclk);
      ta = ta | s_axi_arready;
      s_axi_arvalid <= !ta;
      if (s_axi_rvalid) break;
    end
    tmo(i);
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  ////////////////////////////////////////
  task automatic t_regs;
    rd(12'h810, 32'h0000_00ff, 2'h0);
    rd(12'h814, 32'h0000_00ff, 2'h0);
    rd(12'h820, 32'h0000_00ff, 2'h0);
    rd(12'h824, 32'h0000_00ff, 2'h0);
    rd(12'h804, 32'h0000_0000, 2'h0);
    rd(12'h900, 32'h0000_0000, 2'h2);
    wr(12'h804, 8'h3f);
    rd(12'h804, 32'h0000_003f, 2'h0);
  endtask

  // high byte first leaves 0x00ff loaded: a missed reload overruns the wait
  task automatic t_div(input logic [11:0] base, input logic [7:0] on);
    int i, t0;
    wr(12'h804, on);
    wr(base + 12'h004, 8'h00);
    wr(base, 8'h07);
    t0 = -1;
    for (i = 0; i < 99; i++) begin
      @(posedge aclk);
      if (base == 12'h810 ? tx_clk_en : rx_clk_en) begin
        if (t0 >= 0) break;
        t0 = i;
      end
    end
    tmo(i);
    chk(32'(i - t0), 32'h0000_0007);
  endtask

  task automatic t_lvl;
    int p;
    wr(12'h800, 8'h00);
    for (p = 0; p < 2; p++) begin
      wr(12'h804, p ? 8'h12 : 8'h02);
      tx_busy <= 1'b0;
      cyc(3);
      chk(32'(infrared_out_pin), 32'(p));
      tx_busy <= 1'b1;
      tx_symbol <= 1'b1;
      cyc(3);
      chk(32'(infrared_out_pin), 32'(!p));
      tx_symbol <= 1'b0;
      cyc(3);
      chk(32'(infrared_out_pin), 32'(p));
    end
  endtask

  task automatic t_mod;
    int p;
    logic [7:0] f0;
    wr(12'h800, 8'h20);
    tx_busy <= 1'b1;
    for (p = 0; p < 2; p++) begin
      wr(12'h804, p ? 8'h12 : 8'h02);
      tx_symbol <= p[0];
      cyc(3);
      f0 = flashes;
      cyc(40);
      chk(32'(flashes - f0), 32'h0000_0000);
      chk(32'(infrared_out_pin), 32'h0000_0000);
      tx_symbol <= !p[0];
      cyc(3);
      f0 = flashes;
      cyc(40);
      chk(32'(flashes - f0 > 8'h04), 32'h0000_0001);
    end
  endtask

  task automatic t_req(input logic [7:0] c2, input logic b, input logic [4:0] tl,
      input logic [4:0] rl, input logic [1:0] e);
    wr(12'h804, c2);
    tx_busy <= b;
    tx_fifo_level <= tl;
    rx_fifo_level <= rl;
    cyc(3);
    chk(32'({tx_request, rx_request}), 32'(e));
  endtask

  task automatic t_loop;
    wr(12'h800, 8'h00);
    light <= 1'b0;
    tx_busy <= 1'b1;
    tx_symbol <= 1'b1;
    wr(12'h804, 8'h23);
    cyc(6);
    chk(32'(infrared_out_pin), 32'h0000_0001);
    chk(32'(rx_symbol), 32'h0000_0001);
    wr(12'h804, 8'h03);
    cyc(6);
    chk(32'(rx_symbol), 32'h0000_0000);
    light <= 1'b1;
    cyc(6);
    chk(32'(rx_symbol), 32'h0000_0001);
    wr(12'h804, 8'h02);
    cyc(6);
    chk(32'(rx_symbol), 32'h0000_0000);
    wr(12'h800, 8'h30);
    wr(12'h804, 8'h23);
    cyc(30);
    chk(32'(rx_symbol), 32'h0000_0001);
    tx_symbol <= 1'b0;
    cyc(150);
    chk(32'(rx_symbol), 32'h0000_0000);
  endtask

  ////////////////////////////////////////
  initial begin
    aclk = 0;
    aresetn = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {tx_symbol, tx_busy, light, tx_fifo_level, rx_fifo_level} = '0;
    n_errors = 0;
    total_checks = 0;
    cyc(10);
    aresetn <= 1'b1;
    cyc(1);
    t_regs;
    t_div(12'h810, 8'h02);
    t_div(12'h820, 8'h01);
    t_lvl;
    t_mod;
    t_req(8'h00, 1'b1, 5'h08, 5'h07, 2'h2);
    rd(12'h828, 32'h0000_000a, 2'h0);
    t_req(8'h00, 1'b0, 5'h09, 5'h08, 2'h1);
    t_req(8'h0c, 1'b0, 5'h10, 5'h01, 2'h3);
    t_req(8'h0c, 1'b1, 5'h00, 5'h00, 2'h0);
    t_req(8'h0c, 1'b1, 5'h10, 5'h10, 2'h1);
    t_loop;
    finish_test;
  end
endmodule
